// ---- shared/ivs_pkg.sv ----
package ivs_pkg;

   // program memory address width and vector numbering
   localparam int unsigned ADDR_W        = 24;
   localparam int unsigned VEC_W         = 7;
   localparam int unsigned LEVEL_W       = 4;
   localparam int unsigned PRIO_W        = 3;
   localparam int unsigned NUM_TRAPS     = 8;
   localparam int unsigned NUM_IRQS      = 118;
   localparam int unsigned REG_W         = 16;
   localparam int unsigned FLAG_REGS     = 8;
   localparam int unsigned PRIO_REGS     = 30;
   localparam int unsigned PRIO_PER_REG  = 4;
   localparam int unsigned PRIO_STRIDE   = 4;

   // table layout
   localparam logic [23:0] RESET_ADDR    = 24'h000000;
   localparam logic [23:0] TRAP_BASE     = 24'h000004;
   localparam logic [23:0] TRAP_LAST     = 24'h000012;
   localparam logic [23:0] USER_BASE     = 24'h000014;
   localparam logic [23:0] ALT_OFFSET    = 24'h000100;
   localparam logic [23:0] ALT_TRAP_BASE = 24'h000104;

   // trap numbers
   localparam logic [6:0] TRAP_OSC_FAIL   = 7'h01;
   localparam logic [6:0] TRAP_ADDR_ERR   = 7'h02;
   localparam logic [6:0] TRAP_STACK_ERR  = 7'h03;
   localparam logic [6:0] TRAP_MATH_ERR   = 7'h04;

   // user vector numbers of named sources
   localparam logic [6:0] VEC_EXTERNAL_IRQ_ZERO     = 7'h00;
   localparam logic [6:0] VEC_SERIAL_ONE_RECEIVE    = 7'h0B;
   localparam logic [6:0] VEC_ANALOG_CONVERTER_ONE  = 7'h0D;
   localparam logic [6:0] VEC_NONVOLATILE_WRITE     = 7'h0F;
   localparam logic [6:0] VEC_SYNC_SERIAL_ONE_XFER  = 7'h10;
   localparam logic [6:0] VEC_SYNC_SERIAL_ONE_COLL  = 7'h11;
   localparam logic [6:0] VEC_INPUT_CHANGE_NOTIFY   = 7'h13;
   localparam logic [6:0] VEC_SERIAL_TWO_RECEIVE    = 7'h1E;
   localparam logic [6:0] VEC_CALENDAR_CLOCK        = 7'h3E;
   localparam logic [6:0] VEC_SUPPLY_LEVEL_DETECT   = 7'h48;
   localparam logic [6:0] VEC_LOW_POWER_WAKEUP      = 7'h50;

   // trap requests outrank every user level
   localparam logic [3:0] TRAP_LEVEL = 4'h8;

   typedef enum logic [1:0] {
      ST_BOOT  = 2'b00,
      ST_IDLE  = 2'b01,
      ST_FETCH = 2'b11
   } ivs_state_e;

   // vector fetch request towards the core
   typedef struct packed {
      logic        req;
      logic        is_trap;
      logic        alt;
      logic [6:0]  num;
      logic [3:0]  level;
      logic [23:0] addr;
   } ivs_fetch_s;

   // program counter load towards the core
   typedef struct packed {
      logic        load;
      logic        from_reset;
      logic [23:0] value;
   } ivs_pc_s;

endpackage

// ---- src/ivs_arbiter.sv ----
`timescale 1ns/1ps
`default_nettype none

module ivs_arbiter #(
   parameter int unsigned N      = 118,
   parameter int unsigned IDX_W  = 7,
   parameter int unsigned PRIO_W = 3
) (
   input  wire logic [N-1:0]             req,
   input  wire logic [N-1:0][PRIO_W-1:0] prio,
   output logic                          found,
   output logic [IDX_W-1:0]              index,
   output logic [PRIO_W-1:0]             level
);

   // scan from the top down; >= lets the lower vector win a tie
   always_comb begin
      found = 1'b0;
      index = '0;
      level = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i] && (!found || prio[i] >= level)) begin
            found = 1'b1;
            index = IDX_W'(i);
            level = prio[i];
         end
      end
   end

endmodule

`default_nettype wire

// ---- src/ivs_vector_select.sv ----
`timescale 1ns/1ps
`default_nettype none

module ivs_vector_select #(
   parameter int unsigned NUM_IRQS  = ivs_pkg::NUM_IRQS,
   parameter int unsigned FLAG_REGS = ivs_pkg::FLAG_REGS,
   parameter int unsigned PRIO_REGS = ivs_pkg::PRIO_REGS
) (
   input  wire logic                                      clock,
   input  wire logic                                      rst_n,
   input  wire logic                                      ce,
   input  wire logic                                      alt_table_select,
   input  wire logic [ivs_pkg::NUM_TRAPS-1:0]             trap_req,
   input  wire logic [FLAG_REGS-1:0][ivs_pkg::REG_W-1:0]  irq_flag_regs,
   input  wire logic [FLAG_REGS-1:0][ivs_pkg::REG_W-1:0]  irq_enable_regs,
   input  wire logic [PRIO_REGS-1:0][ivs_pkg::REG_W-1:0]  irq_priority_regs,
   input  wire logic [ivs_pkg::LEVEL_W-1:0]               cpu_level,
   input  wire logic                                      entry_valid,
   input  wire logic [ivs_pkg::ADDR_W-1:0]                entry_data,
   output ivs_pkg::ivs_fetch_s                            fetch,
   output ivs_pkg::ivs_pc_s                               pc_out,
   output logic                                           taken
);

   // whole state of the block
   typedef struct packed {
      ivs_pkg::ivs_state_e state;
      ivs_pkg::ivs_fetch_s fetch;
      ivs_pkg::ivs_pc_s    pc;
      logic                taken;
   } ivs_regs_s;

   ivs_regs_s                                  r;
   ivs_regs_s                                  next_r;

   logic [NUM_IRQS-1:0]                        irq_pending;
   logic [NUM_IRQS-1:0][ivs_pkg::PRIO_W-1:0]   irq_prio;
   logic                                       user_found;
   logic [ivs_pkg::VEC_W-1:0]                  user_num;
   logic [ivs_pkg::PRIO_W-1:0]                 user_level;
   logic                                       trap_found;
   logic [ivs_pkg::VEC_W-1:0]                  trap_num;
   logic                                       user_eligible;

   // per-source unpack: flag and enable bit = vec mod 16 of reg vec/16,
   // priority field = bits 4*(vec mod 4)+2..+0 of reg vec/4
   genvar g;
   generate
      for (g = 0; g < NUM_IRQS; g++) begin : g_src
         localparam int unsigned FREG = g / ivs_pkg::REG_W;
         localparam int unsigned FBIT = g % ivs_pkg::REG_W;
         localparam int unsigned PREG = g / ivs_pkg::PRIO_PER_REG;
         localparam int unsigned PBIT = (g % ivs_pkg::PRIO_PER_REG) * ivs_pkg::PRIO_STRIDE;
         assign irq_prio[g]    = irq_priority_regs[PREG][PBIT +: ivs_pkg::PRIO_W];
         assign irq_pending[g] = irq_flag_regs[FREG][FBIT] && irq_enable_regs[FREG][FBIT];
      end
   endgenerate

   // choice by programmed priority among user sources; lower vector wins a tie
   ivs_arbiter #(
      .N      (NUM_IRQS),
      .IDX_W  (ivs_pkg::VEC_W),
      .PRIO_W (ivs_pkg::PRIO_W)
   ) u_arb (
      .req   (irq_pending),
      .prio  (irq_prio),
      .found (user_found),
      .index (user_num),
      .level (user_level)
   );

   // lowest trap number wins; reserved numbers still vector
   always_comb begin
      trap_found = 1'b0;
      trap_num   = '0;
      for (int t = ivs_pkg::NUM_TRAPS - 1; t >= 0; t--) begin
         if (trap_req[t]) begin
            trap_found = 1'b1;
            trap_num   = ivs_pkg::VEC_W'(t);
         end
      end
   end

   // user level 0 never interrupts; must exceed the core's level
   assign user_eligible = user_found && (user_level != '0)
                          && ({1'b0, user_level} > cpu_level);

   // table entry address of a chosen source
   function automatic logic [23:0] entry_addr(input logic is_trap,
                                              input logic [6:0] num,
                                              input logic alt);
      logic [23:0] base;
      base = is_trap ? ivs_pkg::TRAP_BASE : ivs_pkg::USER_BASE;
      base = base + {16'h0000, num, 1'b0};
      if (alt) begin
         base = base + ivs_pkg::ALT_OFFSET;
      end
      return base;
   endfunction

   // sequencer: boot load of zero, then select, fetch entry, load pc
   always_comb begin
      next_r          = r;
      next_r.pc.load  = 1'b0;
      next_r.taken    = 1'b0;
      unique case (r.state)
         ivs_pkg::ST_BOOT: begin
            // reset start: no lookup, straight to address zero
            next_r.pc.load       = 1'b1;
            next_r.pc.from_reset = 1'b1;
            next_r.pc.value      = ivs_pkg::RESET_ADDR;
            next_r.state         = ivs_pkg::ST_IDLE;
         end
         ivs_pkg::ST_IDLE: begin
            if (trap_found) begin
               next_r.fetch.req     = 1'b1;
               next_r.fetch.is_trap = 1'b1;
               next_r.fetch.alt     = alt_table_select;
               next_r.fetch.num     = trap_num;
               next_r.fetch.level   = ivs_pkg::TRAP_LEVEL;
               next_r.fetch.addr    = entry_addr(1'b1, trap_num, alt_table_select);
               next_r.taken         = 1'b1;
               next_r.state         = ivs_pkg::ST_FETCH;
            end else if (user_eligible) begin
               next_r.fetch.req     = 1'b1;
               next_r.fetch.is_trap = 1'b0;
               next_r.fetch.alt     = alt_table_select;
               next_r.fetch.num     = user_num;
               next_r.fetch.level   = {1'b0, user_level};
               next_r.fetch.addr    = entry_addr(1'b0, user_num, alt_table_select);
               next_r.taken         = 1'b1;
               next_r.state         = ivs_pkg::ST_FETCH;
            end
         end
         ivs_pkg::ST_FETCH: begin
            // entry word returned by the core is the handler start
            if (entry_valid) begin
               next_r.fetch.req     = 1'b0;
               next_r.pc.load       = 1'b1;
               next_r.pc.from_reset = 1'b0;
               next_r.pc.value      = entry_data;
               next_r.state         = ivs_pkg::ST_IDLE;
            end
         end
         default: begin
            next_r.state = ivs_pkg::ST_BOOT;
         end
      endcase
   end

   // state register: reset clears everything, ce freezes
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         r       <= '0;
         r.state <= ivs_pkg::ST_BOOT;
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign fetch  = r.fetch;
   assign pc_out = r.pc;
   assign taken  = r.taken;

endmodule

`default_nettype wire

// ---- verification/ivs_vector_select_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module ivs_checker (
   input wire logic                           clock,
   input wire logic                           rst_n,
   input wire logic                           ce,
   input wire logic                           alt_table_select,
   input wire logic [ivs_pkg::NUM_TRAPS-1:0]  trap_req,
   input wire logic [ivs_pkg::LEVEL_W-1:0]    cpu_level,
   input wire logic                           entry_valid,
   input wire logic [ivs_pkg::ADDR_W-1:0]     entry_data,
   input wire ivs_pkg::ivs_fetch_s            fetch,
   input wire ivs_pkg::ivs_pc_s               pc_out,
   input wire logic                           taken
);
   logic [6:0] low_trap;
   logic [6:0] low_trap_q;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // lowest pending trap number, one edge late
   always_comb begin
      low_trap = 7'h0;
      for (int i = 7; i >= 0; i--) if (trap_req[i]) low_trap = 7'(i);
   end
   always_ff @(posedge clock) begin
      low_trap_q <= low_trap;
   end
   // program counter loads
   sequence s_boot;
      pc_out.load && pc_out.from_reset && pc_out.value == 24'h0 && !fetch.req;
   endsequence
   sequence s_hand;
      pc_out.load && !pc_out.from_reset && pc_out.value == $past(entry_data) && !fetch.req ##1 !pc_out.load;
   endsequence
   a_boot_load: assert property ($rose(rst_n) |=> s_boot) else $error("no zero load after reset");
   a_entry_load: assert property (ce && fetch.req && entry_valid |=> s_hand) else $error("entry not loaded");
   a_req_holds: assert property (fetch.req && !entry_valid |=> fetch.req && $stable(fetch))
      else $error("fetch dropped early");
   a_trap_addr: assert property (fetch.req && fetch.is_trap |-> fetch.level == 4'h8 &&
      fetch.addr == (fetch.alt ? 24'h104 : 24'h4) + {fetch.num, 1'b0}) else $error("bad trap entry");
   a_user_addr: assert property (fetch.req && !fetch.is_trap |->
      fetch.addr == (fetch.alt ? 24'h114 : 24'h14) + {fetch.num, 1'b0}) else $error("bad user entry");
   a_alt_latch: assert property ($rose(taken) |-> fetch.alt == $past(alt_table_select)) else $error("bad table");
   a_trap_first: assert property (taken && $past(|trap_req) |-> fetch.is_trap &&
      fetch.num == low_trap_q) else $error("wrong trap chosen");
   // a frozen edge keeps the pulse up one more cycle
   a_taken_edge: assert property ($rose(fetch.req) |-> taken ##1 (!taken || !$past(ce)))
      else $error("taken not a pulse");
   a_user_level: assert property ($rose(taken) && !fetch.is_trap |-> fetch.level > $past(cpu_level))
      else $error("user level too low");
   // clock enable low holds every output
   a_ce_freeze: assert property (!ce |=> $stable(fetch) && $stable(pc_out) && $stable(taken))
      else $error("state moved while frozen");
endmodule
`default_nettype wire

// ---- verification/ivs_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ivs_core_model (
   input  wire logic                clock,
   input  wire logic                rst_n,
   input  wire ivs_pkg::ivs_fetch_s fetch,
   input  wire logic [3:0]          lat,
   output logic                     entry_valid,
   output logic [23:0]              entry_data
);
   logic [3:0] cnt;
   // answers a fetch lat+1 cycles after req rises, data wanders when released
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cnt         <= 4'h0;
         entry_valid <= 1'b0;
         entry_data  <= 24'h0;
      end else if (entry_valid || !fetch.req) begin
         entry_valid <= 1'b0;
         entry_data  <= ~entry_data;
      end else if (cnt == lat) begin
         cnt         <= 4'h0;
         entry_valid <= 1'b1;
         entry_data  <= (fetch.addr & 24'hFFFEFF) ^ 24'h5A0000;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %s expected %0h seen %0h", n, e, a); end end
module testbench;
   logic                clock = 1'b0;
   logic                rst_n = 1'b0;
   logic                ce = 1'b1;
   logic                alt_table_select = 1'b0;
   logic [7:0]          trap_req = '0;
   logic [7:0][15:0]    flags = '0;
   logic [7:0][15:0]    enables = '0;
   logic [29:0][15:0]   prios = '0;
   logic [3:0]          cpu_level = 4'h3;
   logic [3:0]          lat = 4'h0;
   logic                entry_valid;
   logic [23:0]         entry_data;
   ivs_pkg::ivs_fetch_s fetch;
   ivs_pkg::ivs_pc_s    pc_out;
   logic                taken;
   int                  n_mismatch = 0;
   int                  check_count = 0;
   always #5 clock = ~clock;
   ivs_vector_select u_dut (.clock(clock), .rst_n(rst_n), .ce(ce), .alt_table_select(alt_table_select),
      .trap_req(trap_req), .irq_flag_regs(flags), .irq_enable_regs(enables), .irq_priority_regs(prios),
      .cpu_level(cpu_level), .entry_valid(entry_valid), .entry_data(entry_data), .fetch(fetch),
      .pc_out(pc_out), .taken(taken));
   ivs_core_model u_core (.clock(clock), .rst_n(rst_n), .fetch(fetch), .lat(lat),
      .entry_valid(entry_valid), .entry_data(entry_data));
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic wait_on(input bit want_load);
      int i;
      i = 0;
      while ((want_load ? pc_out.load : taken) !== 1'b1 && i < 40) begin
         @(posedge clock) #1;
         i++;
      end
      `CHK("handshake", 1'b1, want_load ? pc_out.load : taken)
   endtask
   task automatic set_user(input int v, input logic [2:0] p);
      flags[v/16][v%16] = 1'b1;
      enables[v/16][v%16] = 1'b1;
      prios[v/4][4*(v%4) +: 3] = p;
   endtask
   task automatic fetch_one(input bit trap, input int num, input bit alt, input logic [3:0] lvl);
      logic [23:0] addr;
      addr = (trap ? 24'h4 : 24'h14) + 24'(2 * num) + (alt ? 24'h100 : 24'h0);
      wait_on(1'b0);
      `CHK("num", 7'(num), fetch.num)
      `CHK("is_trap", trap, fetch.is_trap)
      `CHK("addr", addr, fetch.addr)
      `CHK("level", lvl, fetch.level)
      `CHK("alt", alt, fetch.alt)
      trap_req = '0;
      flags = '0;
      enables = '0;
      wait_on(1'b1);
      `CHK("handler", (addr & 24'hFFFEFF) ^ 24'h5A0000, pc_out.value)
      `CHK("from_reset", 1'b0, pc_out.from_reset)
      @(posedge clock) #1;
   endtask
   task automatic t_boot;
      rst_n = 1'b0;
      repeat (10) @(posedge clock);
      #1 rst_n = 1'b1;
      @(posedge clock) #1;
      `CHK("boot_load", 2'b11, {pc_out.load, pc_out.from_reset})
      `CHK("boot_value", 24'h0, pc_out.value)
      `CHK("boot_fetch", 1'b0, fetch.req)
   endtask
   task automatic t_traps;
      for (int a = 0; a < 2; a++) for (int n = 0; n < 8; n++) begin
         alt_table_select = a[0];
         trap_req[n] = 1'b1;
         fetch_one(1'b1, n, a[0], 4'h8);
      end
   endtask
   task automatic t_users;
      int vs[11] = '{0, 11, 13, 15, 16, 17, 19, 30, 62, 72, 80};
      lat = 4'h5;
      for (int a = 0; a < 2; a++) for (int i = 0; i < 11; i++) begin
         alt_table_select = a[0];
         set_user(vs[i], 3'(4 + i % 4));
         fetch_one(1'b0, vs[i], a[0], 4'(4 + i % 4));
      end
      alt_table_select = 1'b0;
   endtask
   task automatic t_order;
      trap_req = 8'h14;
      set_user(13, 3'h5);
      fetch_one(1'b1, 2, 1'b0, 4'h8);
      set_user(19, 3'h5);
      set_user(13, 3'h5);
      fetch_one(1'b0, 13, 1'b0, 4'h5);
      set_user(13, 3'h4);
      set_user(19, 3'h6);
      fetch_one(1'b0, 19, 1'b0, 4'h6);
   endtask
   task automatic t_refuse;
      set_user(13, 3'h3);
      repeat (8) begin
         @(posedge clock) #1;
         `CHK("refused", 1'b0, taken)
      end
      cpu_level = 4'h2;
      fetch_one(1'b0, 13, 1'b0, 4'h3);
   endtask
   // clock enable low: no selection while idle, taken held while frozen
   task automatic t_freeze;
      ce = 1'b0;
      trap_req[3] = 1'b1;
      repeat (3) begin
         @(posedge clock) #1;
         `CHK("frozen_idle", 1'b0, taken)
      end
      ce = 1'b1;
      @(posedge clock) #1;
      `CHK("thawed_taken", 1'b1, taken)
      ce = 1'b0;
      repeat (3) begin
         @(posedge clock) #1;
         `CHK("frozen_taken", 1'b1, taken)
      end
      ce = 1'b1;
      trap_req = '0;
      wait_on(1'b1);
      `CHK("frozen_handler", 24'h5A000A, pc_out.value)
      @(posedge clock) #1;
   endtask
   // watchdog against a stalled handshake
   initial begin
      #50000;
      n_mismatch++;
      end_sim();
   end
   // main sequence
   initial begin
      t_boot();
      t_traps();
      t_users();
      t_order();
      t_refuse();
      t_freeze();
      lat = 4'h9;
      trap_req = 8'h02;
      t_boot();
      fetch_one(1'b1, 1, 1'b0, 4'h8);
      end_sim();
   end
endmodule
bind ivs_vector_select ivs_checker u_chk (.clock(clock), .rst_n(rst_n), .ce(ce), .alt_table_select(alt_table_select),
   .trap_req(trap_req), .cpu_level(cpu_level), .entry_valid(entry_valid), .entry_data(entry_data),
   .fetch(fetch), .pc_out(pc_out), .taken(taken));
`default_nettype wire
